// ### logic/codec_dac_gain_mixer_regs.sv
`timescale 1ns/1ps
// Functional notes
// [R1] Left playback muted while playback register bit 15 set; resets muted.
// [R2] Left attenuation bits 14:8, 0.5 dB per code, resets all ones.
// [R3] Right playback muted while bit 7 set; resets muted.
// [R4] Right attenuation bits 6:0, 0.5 dB per code, resets all ones.
// [R5] Sidetone muted while mixer bit 15 set; resets to one.
// [R6] Sidetone gain bits 14:8 from -34.5 dB; code 0x45 is 0 dB, reset.
// [R7] Code 0x5C gives 11.5 dB; higher codes clamp at 12 dB.
// [R8] Input select bits 7:5, codes 0-3 pick single-ended sources.
// [R9] Codes 4-7 form differential mic/aux pairs in code order.
// [R10] Host must not rely on sidetone while select top bit is one.
// [R11] Selected source reaches record converter only while bit 4 set.
// [R12] Cell phone input reaches record converter while bit 3 set.
// [R13] Mixer bits 2:1 reserved, read as zero.
// [R14] Mixer bit 0 reads one when applied sidetone gain matches setting.
// [R15] Playback gain steps 0.5 dB per word clock, or every second.
// [R16] Per-channel playback done flags when applied equals programmed gain.
// [R17] Sidetone gain steps 0.5 dB per word clock until matched.
// [R18] Writes to read-only and reserved mixer bits are ignored.
module codec_dac_gain_mixer_regs
(
   input  wire logic                      mclk_i,
   input  wire logic                      rst_i,
   input  wire logic                      wclk_i,
   input  wire logic                      playback_step_rate_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   input  wire logic [6:0]                reg_addr_i,
   input  wire gain_mixer_pkg::reg_word_t reg_wdata_i,
   output gain_mixer_pkg::reg_word_t      reg_rdata_o,
   output logic                           left_play_mute_o,
   output gain_mixer_pkg::gain_code_t     left_play_atten_o,
   output logic                           right_play_mute_o,
   output gain_mixer_pkg::gain_code_t     right_play_atten_o,
   output logic                           left_play_step_done_o,
   output logic                           right_play_step_done_o,
   output logic                           sidetone_mute_o,
   output gain_mixer_pkg::gain_code_t     sidetone_gain_o,
   output logic                           sidetone_valid_o,
   output logic                           headset_mic_in_o,
   output logic                           handset_mic_in_o,
   output logic                           aux_in_one_o,
   output logic                           aux_in_two_o,
   output logic                           differential_o,
   output logic                           cellular_in_to_record_o
);
   import gain_mixer_pkg::*;
`include "gain_mixer_cfg.svh"

   // ----------------------------------------
   // word clock synchroniser and step strobes
   // ----------------------------------------
   logic [2:0] wclk_sync_r;
   logic       wclk_level_r;
   logic       wclk_agree;
   logic       wclk_rise;
   logic       half_rate_r;
   logic       play_step;

   // a change counts only once the last two stages agree, so a marginal sample cannot step twice
   assign wclk_agree = (wclk_sync_r[1] == wclk_sync_r[2]);
   assign wclk_rise  = wclk_agree & wclk_sync_r[2] & ~wclk_level_r;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wclk_sync_r  <= 3'h0;
         wclk_level_r <= 1'b0;
         half_rate_r  <= 1'b0;
      end else begin
         wclk_sync_r <= {wclk_sync_r[1:0], wclk_i};
         if (wclk_agree) begin
            wclk_level_r <= wclk_sync_r[2];
         end
         if (wclk_rise) begin
            half_rate_r <= ~half_rate_r;
         end
      end
   end

   // [R15] step rate select
   assign play_step = wclk_rise & (~playback_step_rate_i | half_rate_r);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // one compare shared by the write strobes and the read select
   function automatic logic addr_is(input logic [6:0] addr, input logic [6:0] ofs);
      return (addr == ofs);
   endfunction

   reg_word_t play_gain_r;
   reg_word_t mixer_r;
   logic      hit_play;
   logic      hit_mixer;
   logic      wr_play;
   logic      wr_mixer;

   assign hit_play  = addr_is(reg_addr_i, `PLAY_GAIN_OFS);
   assign hit_mixer = addr_is(reg_addr_i, `MIXER_OFS);
   assign wr_play   = reg_wr_i & hit_play;
   assign wr_mixer  = reg_wr_i & hit_mixer;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         play_gain_r <= `PLAY_GAIN_RST;
         mixer_r     <= `MIXER_RST;
      end else begin
         if (wr_play) begin
            play_gain_r <= reg_wdata_i;
         end
         // [R18] writable fields only
         if (wr_mixer) begin
            mixer_r <= reg_wdata_i & `MIXER_WR_MASK;
         end
      end
   end

   // ----------------------------------------
   // soft stepping
   // ----------------------------------------
   gain_code_t left_applied;
   gain_code_t right_applied;
   gain_code_t st_applied;
   logic       left_done;
   logic       right_done;
   logic       st_done;

   // both channels share one strobe, so a balanced change stays balanced while it ramps
   // [R2] left attenuation stepping
   gain_stepper #(.RESET_CODE(`PLAY_ATTEN_RST)) u_left (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .step_i    (play_step),
      .target_i  (play_gain_r[`LEFT_ATTEN_MSB:`LEFT_ATTEN_LSB]),
      .applied_o (left_applied),
      .done_o    (left_done)
   );

   // [R4] right attenuation stepping
   gain_stepper #(.RESET_CODE(`PLAY_ATTEN_RST)) u_right (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .step_i    (play_step),
      .target_i  (play_gain_r[`RIGHT_ATTEN_MSB:`RIGHT_ATTEN_LSB]),
      .applied_o (right_applied),
      .done_o    (right_done)
   );

   // [R17] sidetone stepping every word clock
   gain_stepper #(.RESET_CODE(`ST_GAIN_RST)) u_side (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .step_i    (wclk_rise),
      .target_i  (mixer_r[`ST_GAIN_MSB:`ST_GAIN_LSB]),
      .applied_o (st_applied),
      .done_o    (st_done)
   );

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   input_sel_t sel;
   gain_code_t st_gain_r;
   gain_code_t st_gain_nxt;
   assign sel = input_sel_t'(mixer_r[`IN_SEL_MSB:`IN_SEL_LSB]);

   // the clamp is kept out of the stepper so the done flag still compares the unclamped code
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_gain_r <= `ST_GAIN_RST;
      end else begin
         st_gain_r <= st_gain_nxt;
      end
   end

   // [R1] left mute
   assign left_play_mute_o       = play_gain_r[`LEFT_MUTE_BIT];
   // [R3] right mute
   assign right_play_mute_o      = play_gain_r[`RIGHT_MUTE_BIT];
   assign left_play_atten_o      = left_applied;
   assign right_play_atten_o     = right_applied;
   // [R16] channel done flags
   assign left_play_step_done_o  = left_done;
   assign right_play_step_done_o = right_done;
   // [R5] sidetone mute
   assign sidetone_mute_o        = mixer_r[`ST_MUTE_BIT];
   // [R7] clamp above 12 dB code; [R6] gain from code
   assign st_gain_nxt            = (st_applied > `ST_GAIN_MAX) ? `ST_GAIN_MAX : st_applied;
   assign sidetone_gain_o        = st_gain_r;
   // [R10] differential selection voids sidetone
   assign sidetone_valid_o       = ~mixer_r[`IN_SEL_MSB];

   // [R8] [R9] source decode, [R11] gated by record enable
   logic rec_en;
   assign rec_en           = mixer_r[`SEL_TO_REC_BIT];
   assign differential_o   = rec_en & mixer_r[`IN_SEL_MSB];
   assign headset_mic_in_o = rec_en & (sel == SEL_HEADSET_SE || sel == SEL_HEADSET_AUX_IN_ONE || sel == SEL_HEADSET_AUX_IN_TWO);
   assign handset_mic_in_o = rec_en & (sel == SEL_HANDSET_SE || sel == SEL_HANDSET_AUX_IN_ONE || sel == SEL_HANDSET_AUX_IN_TWO);
   assign aux_in_one_o     = rec_en & (sel == SEL_AUX_IN_ONE_SE || sel == SEL_HEADSET_AUX_IN_ONE || sel == SEL_HANDSET_AUX_IN_ONE);
   assign aux_in_two_o     = rec_en & (sel == SEL_AUX_IN_TWO_SE || sel == SEL_HEADSET_AUX_IN_TWO || sel == SEL_HANDSET_AUX_IN_TWO);
   // [R12] cell phone path
   assign cellular_in_to_record_o = mixer_r[`CELL_TO_REC_BIT];

   // ----------------------------------------
   // read data
   // ----------------------------------------
   reg_word_t mixer_rd;
   reg_word_t rdata_nxt;
   reg_word_t rdata_r;
   // [R13] reserved zero, [R14] done flag
   assign mixer_rd  = {mixer_r[15:3], 2'b00, st_done};
   // unmapped offsets read as zero instead of aliasing a real register
   assign rdata_nxt = hit_play  ? play_gain_r :
                      hit_mixer ? mixer_rd : 16'h0000;

   // read data is held between reads so a slow host can pick it up late
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_r <= 16'h0000;
      end else if (reg_rd_i) begin
         rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata_o = rdata_r;
endmodule

// ### logic/gain_mixer_cfg.svh
`ifndef GAIN_MIXER_CFG_SVH
`define GAIN_MIXER_CFG_SVH

// register offsets
`define PLAY_GAIN_OFS        7'h02
`define MIXER_OFS            7'h03

// playback gain register fields
`define LEFT_MUTE_BIT        15
`define LEFT_ATTEN_MSB       14
`define LEFT_ATTEN_LSB       8
`define RIGHT_MUTE_BIT       7
`define RIGHT_ATTEN_MSB      6
`define RIGHT_ATTEN_LSB      0

// mixer register fields
`define ST_MUTE_BIT          15
`define ST_GAIN_MSB          14
`define ST_GAIN_LSB          8
`define IN_SEL_MSB           7
`define IN_SEL_LSB           5
`define SEL_TO_REC_BIT       4
`define CELL_TO_REC_BIT      3
`define ST_DONE_BIT          0

// reset values, sidetone gain clamp and mixer write mask
`define PLAY_GAIN_RST        16'hFFFF
`define ST_GAIN_RST          7'h45
`define PLAY_ATTEN_RST       7'h7F
`define MIXER_RST            16'hC500
`define ST_GAIN_MAX          7'h5D
`define MIXER_WR_MASK        16'hFFF8

`endif

// ### logic/gain_mixer_pkg.sv
package gain_mixer_pkg;
   typedef logic [6:0]  gain_code_t;
   typedef logic [15:0] reg_word_t;
   typedef enum logic [2:0] {
      SEL_HEADSET_SE, SEL_HANDSET_SE, SEL_AUX_IN_ONE_SE, SEL_AUX_IN_TWO_SE,
      SEL_HEADSET_AUX_IN_ONE, SEL_HEADSET_AUX_IN_TWO, SEL_HANDSET_AUX_IN_ONE, SEL_HANDSET_AUX_IN_TWO
   } input_sel_t;
endpackage

// ### logic/gain_stepper.sv
`timescale 1ns/1ps
// one soft-stepped gain code: moves one code (0.5 dB) per step strobe
module gain_stepper #(
   parameter logic [6:0] RESET_CODE = 7'h7F
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire logic       step_i,
   input  wire logic [6:0] target_i,
   output logic      [6:0] applied_o,
   output logic            done_o
);
   logic [6:0] applied_r;
   logic [6:0] applied_nxt;

   assign applied_nxt = (applied_r < target_i) ? 7'(applied_r + 7'h01) :
                        (applied_r > target_i) ? 7'(applied_r - 7'h01) : applied_r;
   assign applied_o   = applied_r;
   assign done_o      = (applied_r == target_i);

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         applied_r <= RESET_CODE;
      end else if (step_i) begin
         applied_r <= applied_nxt;
      end
   end
endmodule

// ### sim/codec_dac_gain_mixer_regs_tb.sv
`timescale 1ns/1ps
module codec_dac_gain_mixer_regs_tb;
   import gain_mixer_pkg::*;
   logic mclk_i = 1'b0, rst_i = 1'b1, wclk_i = 1'b0, rate = 1'b0, wr, rd, lmu, rmu, ldn, rdn, stm, stv, hs, hn, a1, a2, df, cl;
   logic [6:0] addr;
   reg_word_t wd, rdat, q;
   gain_code_t la, ra, sg;
   int num_errors = 0, tests_run = 0, i;
   always #5 mclk_i = ~mclk_i;
   always #80 wclk_i = ~wclk_i;
   host_port_model u_host (.mclk_i(mclk_i), .reg_rdata_i(rdat), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
      .reg_wdata_o(wd));
   codec_dac_gain_mixer_regs u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .wclk_i(wclk_i), .playback_step_rate_i(rate),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .left_play_mute_o(lmu),
      .left_play_atten_o(la), .right_play_mute_o(rmu), .right_play_atten_o(ra), .left_play_step_done_o(ldn),
      .right_play_step_done_o(rdn), .sidetone_mute_o(stm), .sidetone_gain_o(sg), .sidetone_valid_o(stv),
      .headset_mic_in_o(hs), .handset_mic_in_o(hn), .aux_in_one_o(a1), .aux_in_two_o(a2), .differential_o(df),
      .cellular_in_to_record_o(cl));
   task automatic chk(input reg_word_t seen, input reg_word_t exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // lo and hi bound the cycles to settle: one code per word clock (16 cycles), or per two at half rate
   task automatic play(input reg_word_t d, input int lo, input int hi);
      u_host.wr_reg(7'h02, d);
      chk(16'({ldn, rdn}), 16'h0000);
      for (i = 0; i < 4000 && !(ldn === 1'b1 && rdn === 1'b1 && la === d[14:8]); i++) @(negedge mclk_i);
      chk({lmu, la, rmu, ra}, d);
      chk(16'({ldn, rdn}), 16'h0003);
      chk(16'(i >= lo && i <= hi), 16'h0001);
   endtask
   initial begin
      #200000 num_errors++;
      stop_test();
   end
   initial begin
      repeat (3) @(negedge mclk_i);
      rst_i = 1'b0;
      u_host.rd_reg(7'h02, q);
      chk(q, 16'hFFFF);
      u_host.rd_reg(7'h03, q);
      chk(q, 16'hC501);
      $display("reset values done");
      // 122 steps at full rate, then 10 steps at half rate with both mutes set
      play(16'h0A05, 1936, 1953);
      rate = 1'b1;
      play(16'h9484, 288, 321);
      $display("playback done");
      u_host.wr_reg(7'h03, 16'hFFFF);
      chk(16'({cl, stm, stv}), 16'h0006);
      u_host.rd_reg(7'h03, q);
      chk(q, 16'hFFF8);
      repeat (1500) @(negedge mclk_i);
      u_host.rd_reg(7'h03, q);
      chk(q, 16'hFFF9);
      chk(16'(sg), 16'h005D);
      $display("sidetone done");
      // host never relies on sidetone in differential codes
      for (int c = 0; c < 8; c++) begin
         u_host.wr_reg(7'h03, 16'hC510 | 16'(c << 5));
         chk(16'({hs, hn, a1, a2, df}), 16'({32'h569A1248 >> (c * 4), c[2]} & 5'h1F));
         chk(16'(stv), 16'(!c[2]));
      end
      u_host.wr_reg(7'h03, 16'h4500);
      chk(16'({hs, hn, a1, a2, df, cl, stm}), 16'h0000);
      u_host.rd_reg(7'h01, q);
      chk(q, 16'h0000);
      $display("routing done");
      stop_test();
   end
endmodule

// ### sim/gain_mixer_assertions.sv
`timescale 1ns/1ps
module gain_mixer_assertions (
   input wire logic                       mclk_i,
   input wire logic                       rst_i,
   input wire logic                       reg_wr_i,
   input wire logic                       reg_rd_i,
   input wire logic [6:0]                 reg_addr_i,
   input wire gain_mixer_pkg::reg_word_t  reg_wdata_i,
   input wire gain_mixer_pkg::reg_word_t  reg_rdata_o,
   input wire logic                       left_play_mute_o,
   input wire logic                       right_play_mute_o,
   input wire logic                       sidetone_mute_o,
   input wire gain_mixer_pkg::gain_code_t sidetone_gain_o,
   input wire logic                       headset_mic_in_o,
   input wire logic                       handset_mic_in_o,
   input wire logic                       aux_in_one_o,
   input wire logic                       aux_in_two_o,
   input wire logic                       differential_o,
   input wire logic                       cellular_in_to_record_o
);
   import gain_mixer_pkg::*;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   wire wr_play = reg_wr_i && reg_addr_i == 7'h02;
   wire wr_mix  = reg_wr_i && reg_addr_i == 7'h03;
   wire any_src = headset_mic_in_o | handset_mic_in_o | aux_in_one_o | aux_in_two_o | differential_o;
   a_left_mute: assert property (wr_play |=> left_play_mute_o == $past(reg_wdata_i[15])) else $error("left mute");
   a_right_mute: assert property (wr_play |=> right_play_mute_o == $past(reg_wdata_i[7])) else $error("right mute");
   a_st_mute: assert property (wr_mix |=> sidetone_mute_o == $past(reg_wdata_i[15])) else $error("st mute");
   a_cell_route: assert property (wr_mix |=> cellular_in_to_record_o == $past(reg_wdata_i[3])) else $error("cell");
   a_src_gated: assert property (wr_mix && !reg_wdata_i[4] |=> !any_src) else $error("src gate");
   a_diff_pair: assert property (wr_mix && reg_wdata_i[4] |=> differential_o == $past(reg_wdata_i[7])) else $error("diff");
   a_gain_clamp: assert property (sidetone_gain_o <= 7'h5D) else $error("clamp");
   a_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 7'h03 |=> reg_rdata_o[2:1] == 2'b00) else $error("rsvd");
   cover property (wr_mix && reg_wdata_i[7]);
   cover property (sidetone_gain_o == 7'h5D);
   cover property (reg_rd_i && reg_addr_i == 7'h03);
endmodule
bind codec_dac_gain_mixer_regs gain_mixer_assertions u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .left_play_mute_o(left_play_mute_o), .right_play_mute_o(right_play_mute_o), .sidetone_mute_o(sidetone_mute_o),
   .sidetone_gain_o(sidetone_gain_o), .headset_mic_in_o(headset_mic_in_o), .handset_mic_in_o(handset_mic_in_o),
   .aux_in_one_o(aux_in_one_o), .aux_in_two_o(aux_in_two_o), .differential_o(differential_o),
   .cellular_in_to_record_o(cellular_in_to_record_o));

// ### sim/host_port_model.sv
`timescale 1ns/1ps
module host_port_model (
   input  wire logic                      mclk_i,
   input  wire gain_mixer_pkg::reg_word_t reg_rdata_i,
   output logic                           reg_wr_o,
   output logic                           reg_rd_o,
   output logic [6:0]                     reg_addr_o,
   output gain_mixer_pkg::reg_word_t      reg_wdata_o
);
   import gain_mixer_pkg::*;
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 7'h00;
      reg_wdata_o = 16'h0000;
   end
   task automatic wr_reg(input logic [6:0] a, input reg_word_t d);
      @(negedge mclk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge mclk_i);
      reg_wr_o = 1'b0;
      // stale data is inverted so nothing leans on a held bus
      reg_wdata_o = ~d;
   endtask
   task automatic rd_reg(input logic [6:0] a, output reg_word_t q);
      @(negedge mclk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge mclk_i);
      reg_rd_o = 1'b0;
      q = reg_rdata_i;
   endtask
endmodule
